// File: logic/uart_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctrl_regs.svh"

module uart_ctrl (
  input wire logic clk,
  input wire logic rst,
  // Host register port
  input wire logic [2:0] addr,
  input wire logic cs,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic [7:0] iir_in,
  input wire logic [7:0] msr_in,
  // Serial line
  input wire logic rx_in,
  input wire logic tx_serial_in,
  output logic tx_out,
  // Datapath status
  input wire logic rx_fifo_empty,
  input wire logic rx_level_hit,
  input wire logic rx_char_stb,
  input wire logic [3:0] rx_err_bits,
  input wire logic rx_fifo_err,
  input wire logic tx_fifo_empty,
  input wire logic tx_shift_empty,
  input wire logic tx_fifo_full,
  input wire logic tx_space_hit,
  input wire logic other_int_pending,
  input wire logic [3:0] modem_in,
  // Control toward the datapath
  output logic baud16_tick,
  output logic clk_run,
  output logic sleeping,
  output logic rx_timeout,
  output logic [3:0] rxtx_int_en,
  output logic rhr_read,
  output logic thr_write,
  output logic [7:0] thr_data,
  output logic tx_fifo_reset,
  output logic rx_fifo_reset,
  output logic fifo_enable,
  output logic [7:0] line_ctrl,
  output logic [7:0] modem_ctrl,
  output logic transmit_dma_request_n,
  output logic receive_dma_request_n
);
  import uart_ctrl_pkg::*;

  ctrl_state_s st_r;
  ctrl_state_s st_nxt;
  ctrl_state_s rst_val;

  logic enh_key;
  logic dlab;
  logic enh_en;
  logic rd_hit;
  logic wr_hit;
  logic [15:0] divisor;
  logic tick;
  logic [9:0] to_limit;
  logic [7:0] line_status;
  logic block_mode;
  logic sleep_allowed;
  logic wake;
  logic sleep_ok;
  logic thr_wr_now;
  logic rhr_rd_now;

  // Divisor from the two byte registers
  assign divisor = {st_r.divisor_high_byte, st_r.dll};

  // One generator for both directions, halted while asleep
  baud_gen #() u_baud (
    .clk(clk),
    .rst(rst),
    .run(st_r.power == PWR_AWAKE),
    .prescale4(st_r.modem_control_reg[`MCR_PRESCALE_BIT]),
    .divisor(divisor),
    .tick16(tick)
  );

  always_comb begin
    enh_key = (st_r.line_control_reg == `LCR_ENH_KEY);
    dlab = st_r.line_control_reg[`LCR_DLAB_BIT];
    enh_en = st_r.enhanced_feature_reg[`EFR_ENH_BIT];
    rd_hit = cs && rd_en;
    wr_hit = cs && wr_en;
    block_mode = st_r.fifo_control_reg[`FCR_DMA_BIT] && st_r.fifo_control_reg[`FCR_ENABLE_BIT];
    sleep_allowed = enh_en && st_r.interrupt_enable_reg[`IER_SLEEP_BIT];
    thr_wr_now = wr_hit && (addr == `ADDR_DATA) && !dlab;
    rhr_rd_now = rd_hit && (addr == `ADDR_DATA) && !dlab;
    to_limit = 10'((`TO_WORD_MULT * (`WORD_LEN_BASE + 32'(st_r.line_control_reg[1:0])) + `TO_EXTRA_BITS)
                   * `SAMPLES_PER_BIT);
    line_status = {rx_fifo_err, tx_fifo_empty && tx_shift_empty, tx_fifo_empty,
                   rx_err_bits, !rx_fifo_empty};
    // Any receive edge, modem change or transmit write wakes
    wake = (rx_in != st_r.rx_prev) || (modem_in != st_r.modem_prev) || thr_wr_now;
    // Idle line, empty paths, no other interrupt
    sleep_ok = rx_in && st_r.rx_prev && tx_fifo_empty && tx_shift_empty
               && rx_fifo_empty && !other_int_pending;
  end

  always_comb begin
    rst_val = '0;
    rst_val.interrupt_enable_reg = `REG_RESET;
    rst_val.line_control_reg = `LCR_RESET;
    rst_val.modem_control_reg = `REG_RESET;
    rst_val.enhanced_feature_reg = `REG_RESET;
    rst_val.fifo_control_reg = `REG_RESET;
    // Divisor bytes survive reset
    rst_val.dll = st_r.dll;
    rst_val.divisor_high_byte = st_r.divisor_high_byte;
    rst_val.tx_req_n = 1'b0;
    rst_val.rx_req_n = 1'b1;
    rst_val.rx_prev = 1'b1;
    rst_val.power = PWR_AWAKE;
    rst_val.tx_line = 1'b1;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rhr_rd = rhr_rd_now;
    st_nxt.thr_wr = thr_wr_now;
    st_nxt.tx_rst = 1'b0;
    st_nxt.rx_rst = 1'b0;
    st_nxt.rx_prev = rx_in;
    st_nxt.modem_prev = modem_in;

    // Register reads, shared addresses steered by control bits
    if (rd_hit) begin
      st_nxt.rd_data = 8'h00;
      unique case (addr)
        `ADDR_DATA: begin
          if (dlab) begin
            st_nxt.rd_data = st_r.dll;
          end
        end
        `ADDR_IER: begin
          st_nxt.rd_data = dlab ? st_r.divisor_high_byte : st_r.interrupt_enable_reg;
        end
        `ADDR_FCR: begin
          st_nxt.rd_data = enh_key ? st_r.enhanced_feature_reg : iir_in;
        end
        `ADDR_LCR: begin
          st_nxt.rd_data = st_r.line_control_reg;
        end
        `ADDR_MCR: begin
          if (!enh_key) begin
            st_nxt.rd_data = st_r.modem_control_reg;
          end
        end
        `ADDR_LSR: begin
          if (!enh_key) begin
            st_nxt.rd_data = line_status;
          end
        end
        `ADDR_MSR: begin
          if (!enh_key) begin
            st_nxt.rd_data = msr_in;
          end
        end
        default: begin
          st_nxt.rd_data = 8'h00;
        end
      endcase
    end

    // Register writes
    if (wr_hit) begin
      unique case (addr)
        `ADDR_DATA: begin
          if (dlab) begin
            st_nxt.dll = wr_data;
          end else begin
            st_nxt.thr_data = wr_data;
          end
        end
        `ADDR_IER: begin
          if (dlab) begin
            st_nxt.divisor_high_byte = wr_data;
          end else if (enh_en) begin
            st_nxt.interrupt_enable_reg = wr_data;
          end else begin
            st_nxt.interrupt_enable_reg = (st_r.interrupt_enable_reg & `IER_PROT_MASK) | (wr_data & ~`IER_PROT_MASK);
          end
        end
        `ADDR_FCR: begin
          if (enh_key) begin
            st_nxt.enhanced_feature_reg = wr_data;
          end else begin
            if (enh_en) begin
              st_nxt.fifo_control_reg = wr_data;
            end else begin
              st_nxt.fifo_control_reg = (st_r.fifo_control_reg & `FCR_PROT_MASK) | (wr_data & ~`FCR_PROT_MASK);
            end
            st_nxt.fifo_control_reg[`FCR_RXRST_BIT] = 1'b0;
            st_nxt.fifo_control_reg[`FCR_TXRST_BIT] = 1'b0;
            st_nxt.rx_rst = wr_data[`FCR_RXRST_BIT];
            st_nxt.tx_rst = wr_data[`FCR_TXRST_BIT];
          end
        end
        `ADDR_LCR: begin
          st_nxt.line_control_reg = wr_data;
        end
        `ADDR_MCR: begin
          if (!enh_key) begin
            if (enh_en) begin
              st_nxt.modem_control_reg = wr_data;
            end else begin
              st_nxt.modem_control_reg = (st_r.modem_control_reg & `MCR_PROT_MASK) | (wr_data & ~`MCR_PROT_MASK);
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Idle count in sample ticks while data waits
    if (rx_fifo_empty || rx_char_stb || rhr_rd_now) begin
      st_nxt.to_cnt = 10'h000;
      st_nxt.timeout = 1'b0;
    end else if (!rx_in) begin
      st_nxt.to_cnt = 10'h000;
    end else if (tick && !st_r.timeout) begin
      if (st_r.to_cnt >= to_limit - 10'h001) begin
        st_nxt.timeout = 1'b1;
      end else begin
        st_nxt.to_cnt = st_r.to_cnt + 10'h001;
      end
    end

    // DMA request signalling
    if (!block_mode) begin
      st_nxt.tx_req_n = !tx_fifo_empty;
      st_nxt.rx_req_n = rx_fifo_empty;
    end else begin
      if (tx_space_hit) begin
        st_nxt.tx_req_n = 1'b0;
      end else if (tx_fifo_full) begin
        st_nxt.tx_req_n = 1'b1;
      end
      if (rx_level_hit || st_r.timeout) begin
        st_nxt.rx_req_n = 1'b0;
      end else if (rx_fifo_empty || rx_fifo_err) begin
        st_nxt.rx_req_n = 1'b1;
      end
    end

    // Sleep control
    unique case (st_r.power)
      PWR_AWAKE: begin
        if (sleep_allowed && sleep_ok && !wake) begin
          st_nxt.power = PWR_ASLEEP;
        end
      end
      PWR_ASLEEP: begin
        if (wake || !sleep_allowed) begin
          st_nxt.power = PWR_AWAKE;
        end
      end
    endcase

    // Break overrides the serializer
    st_nxt.tx_line = st_r.line_control_reg[`LCR_BREAK_BIT] ? 1'b0 : tx_serial_in;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= rst_val;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd_data;
  assign tx_out = st_r.tx_line;
  // Baud tick gated off while asleep
  assign baud16_tick = tick && (st_r.power == PWR_AWAKE);
  assign clk_run = (st_r.power == PWR_AWAKE);
  assign sleeping = (st_r.power == PWR_ASLEEP);
  assign rx_timeout = st_r.timeout;
  // All zero means polled operation
  assign rxtx_int_en = st_r.interrupt_enable_reg[3:0];
  assign rhr_read = st_r.rhr_rd;
  assign thr_write = st_r.thr_wr;
  assign thr_data = st_r.thr_data;
  assign tx_fifo_reset = st_r.tx_rst;
  assign rx_fifo_reset = st_r.rx_rst;
  assign fifo_enable = st_r.fifo_control_reg[`FCR_ENABLE_BIT];
  assign line_ctrl = st_r.line_control_reg;
  assign modem_ctrl = st_r.modem_control_reg;
  assign transmit_dma_request_n = st_r.tx_req_n;
  assign receive_dma_request_n = st_r.rx_req_n;

endmodule
`default_nettype wire

// File: logic/uart_ctrl_regs.svh
`ifndef UART_CTRL_REGS_SVH
`define UART_CTRL_REGS_SVH

`define ADDR_DATA 3'h0
`define ADDR_IER 3'h1
`define ADDR_FCR 3'h2
`define ADDR_LCR 3'h3
`define ADDR_MCR 3'h4
`define ADDR_LSR 3'h5
`define ADDR_MSR 3'h6

`define LCR_DLAB_BIT 7
`define LCR_BREAK_BIT 6
`define LCR_ENH_KEY 8'hBF
`define MCR_PRESCALE_BIT 7
`define FCR_ENABLE_BIT 0
`define FCR_RXRST_BIT 1
`define FCR_TXRST_BIT 2
`define FCR_DMA_BIT 3
`define EFR_ENH_BIT 4
`define IER_SLEEP_BIT 4

`define IER_PROT_MASK 8'hF0
`define MCR_PROT_MASK 8'hE0
`define FCR_PROT_MASK 8'h30

`define LCR_RESET 8'h1D
`define REG_RESET 8'h00
`define DIV_RESET 8'h00

`define TO_WORD_MULT 4
`define TO_EXTRA_BITS 12
`define WORD_LEN_BASE 5
`define SAMPLES_PER_BIT 16
`define PRESCALE_DIV 4

`endif

// File: logic/uart_ctrl_pkg.sv
package uart_ctrl_pkg;

  typedef enum logic [0:0] {
    PWR_AWAKE = 1'b0,
    PWR_ASLEEP = 1'b1
  } power_e;

  typedef struct packed {
    logic [1:0] pre_cnt;
    logic [15:0] div_cnt;
    logic tick;
  } baud_state_s;

  typedef struct packed {
    logic [7:0] interrupt_enable_reg;
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] dll;
    logic [7:0] divisor_high_byte;
    logic [7:0] rd_data;
    logic rhr_rd;
    logic thr_wr;
    logic [7:0] thr_data;
    logic tx_rst;
    logic rx_rst;
    logic [9:0] to_cnt;
    logic timeout;
    logic tx_req_n;
    logic rx_req_n;
    logic rx_prev;
    logic [3:0] modem_prev;
    power_e power;
    logic tx_line;
  } ctrl_state_s;

endpackage

// File: logic/baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctrl_regs.svh"

module baud_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic prescale4,
  input wire logic [15:0] divisor,
  output logic tick16
);
  import uart_ctrl_pkg::*;

  baud_state_s st_r;
  baud_state_s st_nxt;
  logic pre_en;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    pre_en = 1'b0;
    if (run) begin
      // Divide-by-4 prescaler ahead of the divisor
      if (prescale4) begin
        st_nxt.pre_cnt = st_r.pre_cnt + 2'h1;
        pre_en = (st_r.pre_cnt == 2'(`PRESCALE_DIV - 1));
      end else begin
        st_nxt.pre_cnt = 2'h0;
        pre_en = 1'b1;
      end
      // Zero divisor never ticks; else one tick per divisor
      if (pre_en && divisor != 16'h0000) begin
        if (st_r.div_cnt >= divisor - 16'h0001) begin
          st_nxt.div_cnt = 16'h0000;
          st_nxt.tick = 1'b1;
        end else begin
          st_nxt.div_cnt = st_r.div_cnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick16 = st_r.tick;

endmodule
`default_nettype wire

// File: verification/uart_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uart_ctrl_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic cs,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic rx_in,
  input wire logic tx_serial_in,
  input wire logic tx_out,
  input wire logic rx_fifo_empty,
  input wire logic tx_fifo_empty,
  input wire logic tx_shift_empty,
  input wire logic other_int_pending,
  input wire logic [3:0] modem_in,
  input wire logic baud16_tick,
  input wire logic clk_run,
  input wire logic sleeping,
  input wire logic rx_timeout,
  input wire logic rhr_read,
  input wire logic thr_write,
  input wire logic fifo_enable,
  input wire logic [7:0] line_ctrl,
  input wire logic transmit_dma_request_n,
  input wire logic receive_dma_request_n
);
  logic [1:0] up_r;
  logic live;
  // Keeps history checks off the first edges after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h2) begin
      up_r <= up_r + 2'h1;
    end
  end
  assign live = (up_r == 2'h2);

  break_low_a: assert property (@(posedge clk) disable iff (rst)
    live && line_ctrl[6] && $past(line_ctrl[6]) |-> !tx_out) else $error("tx_out not low during break");
  tx_pass_a: assert property (@(posedge clk) disable iff (rst)
    live && !line_ctrl[6] && !$past(line_ctrl[6]) |-> tx_out == $past(tx_serial_in)) else $error("tx_out bad");
  mode0_tx_a: assert property (@(posedge clk) disable iff (rst)
    live && !fifo_enable && !$past(fifo_enable) |-> transmit_dma_request_n == !$past(tx_fifo_empty))
    else $error("tx request wrong in mode 0");
  mode0_rx_a: assert property (@(posedge clk) disable iff (rst)
    live && !fifo_enable && !$past(fifo_enable) |-> receive_dma_request_n == $past(rx_fifo_empty))
    else $error("rx request wrong in mode 0");
  sleep_gate_a: assert property (@(posedge clk) disable iff (rst)
    sleeping |-> !baud16_tick && !clk_run) else $error("clocks run while asleep");
  sleep_entry_a: assert property (@(posedge clk) disable iff (rst)
    live && $rose(sleeping) |-> $past(tx_fifo_empty && tx_shift_empty && rx_fifo_empty && rx_in && !other_int_pending))
    else $error("sleep entered while busy");
  modem_wake_a: assert property (@(posedge clk) disable iff (rst)
    live && sleeping && modem_in != $past(modem_in) |-> ##[1:3] !sleeping) else $error("no wake on modem change");
  rhr_pulse_a: assert property (@(posedge clk) disable iff (rst)
    live |-> rhr_read == $past(cs && rd_en && addr == 3'h0 && !line_ctrl[7])) else $error("rhr_read wrong");
  thr_pulse_a: assert property (@(posedge clk) disable iff (rst)
    live |-> thr_write == $past(cs && wr_en && addr == 3'h0 && !line_ctrl[7])) else $error("thr_write wrong");
  timeout_clear_a: assert property (@(posedge clk) disable iff (rst)
    live && $past(rx_fifo_empty) |-> !rx_timeout) else $error("timeout set with empty fifo");
endmodule

bind uart_ctrl uart_ctrl_checker uart_ctrl_checker_i (.clk, .rst, .addr, .cs, .rd_en, .wr_en, .rx_in,
  .tx_serial_in, .tx_out, .rx_fifo_empty, .tx_fifo_empty, .tx_shift_empty, .other_int_pending, .modem_in,
  .baud16_tick, .clk_run, .sleeping, .rx_timeout, .rhr_read, .thr_write, .fifo_enable, .line_ctrl,
  .transmit_dma_request_n, .receive_dma_request_n);
`default_nettype wire

// File: verification/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic poke,
  output logic rx_in
);
  logic [4:0] cnt_r = 5'h00;
  // Line marks high when idle; a poke sends a 16-cycle low start
  always @(posedge clk) begin
    if (poke && cnt_r == 5'h00) begin
      cnt_r <= 5'h10;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end
  assign rx_in = (cnt_r == 5'h00);
endmodule
`default_nettype wire

// File: verification/uart_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_ctrl_tb;
  localparam int TO_TICKS = (4 * (5 + 3) + 12) * 16;
  logic clk = 1'b0, rst = 1'b1, cs = 1'b0, rd_en = 1'b0, wr_en = 1'b0, tx_serial_in = 1'b1;
  logic rx_fifo_empty = 1'b1, tx_fifo_empty = 1'b1, other_int_pending = 1'b0, rd_take = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00, rd_data;
  logic [3:0] modem_in = 4'h0, rxtx_int_en;
  logic [5:0] pz = 6'h00;
  logic rx_in, tx_out, baud16_tick, clk_run, sleeping, rx_timeout, tx_req_n, rx_req_n;
  logic [2:0] mon;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0000001C;
  logic [31:0] r;
  int errors = 0, total_checks = 0;

  uart_ctrl uart_ctrl_i (.clk(clk), .rst(rst), .addr(addr), .cs(cs), .rd_en(rd_en), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .iir_in(8'hC1), .msr_in(8'h5A), .rx_in(rx_in),
    .tx_serial_in(tx_serial_in), .tx_out(tx_out), .rx_fifo_empty(rx_fifo_empty), .rx_level_hit(pz[2]),
    .rx_char_stb(pz[4]), .rx_err_bits(4'h0), .rx_fifo_err(pz[3]), .tx_fifo_empty(tx_fifo_empty),
    .tx_shift_empty(1'b1), .tx_fifo_full(pz[0]), .tx_space_hit(pz[1]), .other_int_pending(other_int_pending),
    .modem_in(modem_in), .baud16_tick(baud16_tick), .clk_run(clk_run), .sleeping(sleeping),
    .rx_timeout(rx_timeout), .rxtx_int_en(rxtx_int_en), .rhr_read(), .thr_write(), .thr_data(),
    .tx_fifo_reset(), .rx_fifo_reset(), .fifo_enable(), .line_ctrl(), .modem_ctrl(),
    .transmit_dma_request_n(tx_req_n), .receive_dma_request_n(rx_req_n));
  serial_peer serial_peer_i (.clk(clk), .poke(pz[5]), .rx_in(rx_in));
  assign mon = {rx_timeout, sleeping, baud16_tick};

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic final_report();
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_on(input int i, input logic v, input int lim);
    int k;
    k = 0;
    total_checks++;
    @(negedge clk);
    while (mon[i] !== v) begin
      @(negedge clk);
      k++;
      if (k > lim) begin
        errors++;
        final_report();
      end
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    cs <= 1'b1;
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    cs <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    cs <= 1'b1;
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    cs <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    pz[i] <= 1'b1;
    @(posedge clk);
    pz[i] <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic set_div(input logic [15:0] d);
    wr(3'h3, 8'h80);
    wr(3'h0, d[7:0]);
    wr(3'h1, d[15:8]);
    wr(3'h3, 8'h03);
  endtask

  task automatic gap(input logic [15:0] exp);
    int n;
    n = 0;
    wait_on(0, 1'b1, 400);
    do begin
      @(negedge clk);
      n++;
    end while (mon[0] !== 1'b1 && n < 400);
    check(16'(n), exp);
  endtask

  // Read results land one cycle after the read is taken
  always @(posedge clk) rd_take <= cs && rd_en;
  always @(negedge clk) begin
    if (rd_take && exp_q.size() > 0) begin
      check({8'h00, rd_data}, {8'h00, exp_q.pop_front()});
    end
  end
  always @(posedge clk) tx_serial_in <= ^rnd();

  initial begin
    int n;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(3'h3, 8'h1D);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'hC1);
    rd(3'h5, 8'h60);
    rd(3'h6, 8'h5A);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h0F);
    wr(3'h1, 8'h00);
    r = rnd();
    wr(3'h3, 8'h80);
    wr(3'h0, r[7:0]);
    wr(3'h1, r[15:8]);
    rd(3'h0, r[7:0]);
    rd(3'h1, r[15:8]);
    wr(3'h3, 8'h03);
    rd(3'h1, 8'h00);
    set_div(16'h000C);
    gap(16'h000C);
    wr(3'h4, 8'h80);
    rd(3'h4, 8'h00);
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h10);
    rd(3'h2, 8'h10);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h80);
    gap(16'h0030);
    wr(3'h4, 8'h00);
    set_div(16'h0000);
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (baud16_tick === 1'b1) n++;
    end
    check(16'(n), 16'h0000);
    wr(3'h3, 8'h43);
    repeat (3) @(negedge clk);
    check(16'(tx_out), 16'h0000);
    wr(3'h3, 8'h03);
    repeat (20) begin
      @(posedge clk);
      r = rnd();
      tx_fifo_empty <= r[0];
      rx_fifo_empty <= r[1];
    end
    @(posedge clk);
    tx_fifo_empty <= 1'b0;
    rx_fifo_empty <= 1'b0;
    repeat (2) @(negedge clk);
    check(16'({tx_req_n, rx_req_n}), 16'h0002);
    @(posedge clk);
    tx_fifo_empty <= 1'b1;
    wr(3'h2, 8'h09);
    pulse(0);
    check(16'(tx_req_n), 16'h0001);
    pulse(1);
    check(16'(tx_req_n), 16'h0000);
    pulse(3);
    check(16'(rx_req_n), 16'h0001);
    pulse(2);
    check(16'(rx_req_n), 16'h0000);
    pulse(3);
    check(16'(rx_req_n), 16'h0001);
    @(posedge clk);
    rx_fifo_empty <= 1'b1;
    set_div(16'h0001);
    @(posedge clk);
    rx_fifo_empty <= 1'b0;
    repeat (TO_TICKS - 14) @(negedge clk);
    check(16'(rx_timeout), 16'h0000);
    wait_on(2, 1'b1, 40);
    repeat (2) @(negedge clk);
    check(16'(rx_req_n), 16'h0000);
    pulse(4);
    check(16'(rx_timeout), 16'h0000);
    @(posedge clk);
    rx_fifo_empty <= 1'b1;
    wr(3'h1, 8'h10);
    check(16'(rxtx_int_en), 16'h0000);
    wait_on(1, 1'b1, 20);
    check(16'(clk_run), 16'h0000);
    wr(3'h0, 8'h55);
    wait_on(1, 1'b0, 5);
    wait_on(1, 1'b1, 20);
    @(posedge clk);
    modem_in <= 4'h3;
    wait_on(1, 1'b0, 5);
    wait_on(1, 1'b1, 20);
    pulse(5);
    wait_on(1, 1'b0, 5);
    @(posedge clk);
    other_int_pending <= 1'b1;
    repeat (40) @(negedge clk);
    check(16'(sleeping), 16'h0000);
    wr(3'h1, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
